// ===== i2cra_ctl.sv
// Purpose: Bus controller model
// Assumes: Pull-up on data, quarter bit of 1 us
// Notes: Only pulls data low
`timescale 1ns/10ps
module i2cra_ctl (
  input wire logic i_clk,
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda_low
);
  initial begin
    o_scl = 1'b1;
    o_sda_low = 1'b0;
  end
  task automatic st(input logic s, input logic d);
    o_scl = s;
    o_sda_low = d;
    repeat (10) @(negedge i_clk);
  endtask
  task automatic start;
    st(o_scl, 1'b0);
    st(1'b1, 1'b0);
    st(1'b1, 1'b1);
    st(1'b0, 1'b1);
  endtask
  task automatic stop;
    st(1'b0, 1'b1);
    st(1'b1, 1'b1);
    st(1'b1, 1'b0);
    repeat (30) @(negedge i_clk);
  endtask
  // Idle after a write while the device is in suspend
  task automatic idle_suspend;
    repeat (4500) @(negedge i_clk);
  endtask
  task automatic bit_io(input logic b, output logic r);
    st(1'b0, !b);
    st(1'b1, !b);
    r = i_sda;
    st(1'b1, !b);
    st(1'b0, !b);
  endtask
  task automatic wr(input logic [7:0] d, output logic ack);
    logic r;
    for (int k = 7; k >= 0; k--) begin
      bit_io(d[k], r);
    end
    bit_io(1'b1, ack);
  endtask
  task automatic rd(input logic nack, output logic [7:0] d);
    logic r;
    for (int k = 7; k >= 0; k--) begin
      bit_io(1'b1, d[k]);
    end
    bit_io(nack, r);
  endtask
endmodule // i2cra_ctl

// ===== i2cra_pin_sync.sv
// Purpose: Two-stage synchroniser with start and stop detection
// Assumes: Inputs are bus pins from outside the clock domain
// Notes: Only the two stages after the synchroniser feed edge detection
`timescale 1ns/10ps
module i2cra_pin_sync (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda,
  output logic o_scl_rise,
  output logic o_scl_fall,
  output logic o_start,
  output logic o_stop
);
  typedef struct packed {
    logic [1:0] scl_meta;
    logic [1:0] sda_meta;
    logic scl_q;
    logic sda_q;
    logic scl_d;
    logic sda_d;
  } i2cra_sync_t;
  i2cra_sync_t sync_reg;
  i2cra_sync_t sync_next;

  always_comb begin
    sync_next = sync_reg;
    sync_next.scl_meta = {sync_reg.scl_meta[0], i_scl};
    sync_next.sda_meta = {sync_reg.sda_meta[0], i_sda};
    sync_next.scl_d = sync_reg.scl_meta[1];
    sync_next.sda_d = sync_reg.sda_meta[1];
    sync_next.scl_q = sync_reg.scl_d;
    sync_next.sda_q = sync_reg.sda_d;
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sync_reg <= '1;
    end else begin
      sync_reg <= sync_next;
    end
  end

  assign o_scl = sync_reg.scl_d;
  assign o_sda = sync_reg.sda_d;
  assign o_scl_rise = sync_reg.scl_d & ~sync_reg.scl_q;
  assign o_scl_fall = ~sync_reg.scl_d & sync_reg.scl_q;
  assign o_start = sync_reg.scl_d & sync_reg.scl_q & sync_reg.sda_q & ~sync_reg.sda_d;
  assign o_stop = sync_reg.scl_d & sync_reg.scl_q & ~sync_reg.sda_q & sync_reg.sda_d;
endmodule // i2cra_pin_sync

// ===== i2cra_pkg.sv
// Purpose: Shared constants and types for the two-wire register access target
// Assumes: 10 MHz reference clock, bus pins sampled through two flip-flops
// Notes: Bus-hang periods are counts of reference clock cycles
package i2cra_pkg;
  localparam logic [5:0] ADDR_BASE = 6'h34;
  localparam logic [7:0] REG_ADDR_RESET = 8'h00;
  localparam int CLK_MHZ = 10;
  localparam int HANG_SHORT_MS = 1;
  localparam int HANG_LONG_MS = 50;
  localparam int HANG_SHORT_CYC = HANG_SHORT_MS * 1000 * CLK_MHZ;
  localparam int HANG_LONG_CYC = HANG_LONG_MS * 1000 * CLK_MHZ;
  localparam int HANG_W = 20;
  localparam logic [3:0] BIT_ACK = 4'h8;

  typedef enum logic [5:0] {
    I2CRA_IDLE = 6'h01,
    I2CRA_DEVADR = 6'h02,
    I2CRA_ACK = 6'h04,
    I2CRA_RX = 6'h08,
    I2CRA_TX = 6'h10,
    I2CRA_MACK = 6'h20
  } i2cra_state_t;

  typedef struct packed {
    logic sda_o;
    logic sda_oe;
  } i2cra_pin_t;

  typedef struct packed {
    logic wr_stb;
    logic rd_stb;
    logic [7:0] addr;
    logic [7:0] wdata;
  } i2cra_regreq_t;
endpackage

// ===== i2cra_target.sv
// Purpose: Two-wire target port giving byte access to a register space
// Assumes: Register space answers reads combinationally on i_rdata
// Notes: Bus-hang timer clears the port state when the port holds data low
//
// Behaviour
// [RL1] Acknowledge own write address, then release
// [RL2] Take register address, then data, acknowledge each
// [RL3] Further write bytes increment address unless trapped
// [RL4] Controller reads after address write, repeated start
// [RL5] Controller acknowledge continues; no-acknowledge releases line
// [RL6] Increment register address after each sent byte; code holds it while i_trap is high
// [RL7] Read starts at latest written register address
// [RL8] Start address is zero after reset
// [RL9] Bus-hang timer resets port on lock-up
// [RL10] Timer enable and period select inputs
// [RL11] Controller idles 2 us after write, normal; the stop task idles 3 us after its last step
// [RL12] Controller idles 450 us after write, suspend
// [RL13] Address select pin gives address bit zero
// [RL14] Only 7-bit target addressing is answered
// [RL15] Stop right after start is ignored
// [RL16] Start or stop mid-byte abandons the byte
`timescale 1ns/10ps
module i2cra_target #(
  parameter int HANG_SHORT = i2cra_pkg::HANG_SHORT_CYC,
  parameter int HANG_LONG = i2cra_pkg::HANG_LONG_CYC
) (
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic i_address_select_pin,
  input wire logic i_bus_hang_timer_on,
  input wire logic i_bus_hang_period_select,
  input wire logic i_trap,
  input wire logic [7:0] i_rdata,
  output i2cra_pkg::i2cra_pin_t o_sda,
  output i2cra_pkg::i2cra_regreq_t o_req,
  output logic o_hang_reset
);
  localparam int HANG_W_L = i2cra_pkg::HANG_W + 6;
  typedef struct packed {
    logic [1:0] rst_sync;
    logic [1:0] sel_sync;
    i2cra_pkg::i2cra_state_t state;
    logic [7:0] shift;
    logic [3:0] bitcnt;
    logic is_read;
    logic got_reg;
    logic toggled;
    logic [7:0] reg_addr;
    logic [7:0] start_addr;
    logic [HANG_W_L-1:0] hang_cnt;
    logic hang;
    i2cra_pkg::i2cra_pin_t pin;
    i2cra_pkg::i2cra_regreq_t req;
  } i2cra_core_t;

  i2cra_core_t core_reg;
  i2cra_core_t core_next;
  logic rst_n;
  logic scl;
  logic sda;
  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;
  logic [HANG_W_L-1:0] hang_lim;

  function automatic logic [7:0] next_addr(input logic [7:0] a, input logic trap);
    next_addr = trap ? a : a + 8'h01;
  endfunction

  assign rst_n = core_reg.rst_sync[1];

  i2cra_pin_sync u_sync (
    .i_ref_clk(i_ref_clk),
    .i_rst_n(rst_n),
    .i_scl(i_scl),
    .i_sda(i_sda),
    .o_scl(scl),
    .o_sda(sda),
    .o_scl_rise(scl_rise),
    .o_scl_fall(scl_fall),
    .o_start(start_c),
    .o_stop(stop_c)
  );

  // Long period is a simulation-shortenable parameter
  // Period select is a configuration level of this clock domain
  assign hang_lim = i_bus_hang_period_select ? HANG_W_L'(HANG_LONG) : HANG_W_L'(HANG_SHORT); // RL10

  always_comb begin
    core_next = core_reg;
    core_next.rst_sync = {core_reg.rst_sync[0], 1'b1};
    core_next.sel_sync = {core_reg.sel_sync[0], i_address_select_pin};
    core_next.req.wr_stb = 1'b0;
    core_next.req.rd_stb = 1'b0;
    core_next.hang = 1'b0;
    if (scl_rise || scl_fall) begin
      core_next.toggled = 1'b1;
    end
    // Count only while this port pulls data low
    if (i_bus_hang_timer_on && core_reg.pin.sda_oe && !core_reg.pin.sda_o) begin // RL9
      core_next.hang_cnt = core_reg.hang_cnt + HANG_W_L'(1);
    end else begin
      core_next.hang_cnt = '0;
    end
    if (core_reg.hang_cnt >= hang_lim && i_bus_hang_timer_on) begin // RL9
      core_next.hang = 1'b1;
      core_next.state = i2cra_pkg::I2CRA_IDLE;
      core_next.pin = '0;
      core_next.hang_cnt = '0;
    end else if (start_c) begin // RL16
      core_next.state = i2cra_pkg::I2CRA_DEVADR;
      core_next.bitcnt = 4'h0;
      core_next.pin = '0;
      core_next.toggled = 1'b0;
      core_next.got_reg = 1'b0;
    end else if (stop_c && core_reg.toggled) begin // RL15
      core_next.state = i2cra_pkg::I2CRA_IDLE; // RL16
      core_next.pin = '0;
    end else begin
      case (core_reg.state)
        i2cra_pkg::I2CRA_IDLE: begin
          core_next.pin = '0;
        end
        i2cra_pkg::I2CRA_DEVADR, i2cra_pkg::I2CRA_RX: begin
          if (scl_rise) begin
            core_next.shift = {core_reg.shift[6:0], sda};
            core_next.bitcnt = core_reg.bitcnt + 4'h1;
          end
          if (scl_fall && core_reg.bitcnt == i2cra_pkg::BIT_ACK) begin
            core_next.bitcnt = 4'h0;
            if (core_reg.state == i2cra_pkg::I2CRA_DEVADR) begin
              // Seven-bit match only; ten-bit headers never match
              if (core_reg.shift[7:1] == {i2cra_pkg::ADDR_BASE, core_reg.sel_sync[1]}) begin // RL13 RL14
                core_next.state = i2cra_pkg::I2CRA_ACK; // RL1
                core_next.pin = '{sda_o: 1'b0, sda_oe: 1'b1};
                core_next.is_read = core_reg.shift[0];
                core_next.reg_addr = core_reg.shift[0] ? core_reg.start_addr : core_reg.reg_addr; // RL7 RL4
                core_next.req.addr = core_reg.start_addr;
              end else begin
                core_next.state = i2cra_pkg::I2CRA_IDLE;
              end
            end else if (!core_reg.got_reg) begin
              core_next.got_reg = 1'b1; // RL2
              core_next.reg_addr = core_reg.shift;
              core_next.start_addr = core_reg.shift; // RL7
              core_next.state = i2cra_pkg::I2CRA_ACK;
              core_next.pin = '{sda_o: 1'b0, sda_oe: 1'b1};
            end else begin
              core_next.req.wr_stb = 1'b1; // RL2
              core_next.req.addr = core_reg.reg_addr;
              core_next.req.wdata = core_reg.shift;
              core_next.reg_addr = next_addr(core_reg.reg_addr, i_trap); // RL3
              core_next.state = i2cra_pkg::I2CRA_ACK;
              core_next.pin = '{sda_o: 1'b0, sda_oe: 1'b1};
            end
          end
        end
        i2cra_pkg::I2CRA_ACK: begin
          if (scl_fall) begin
            core_next.pin = '0; // RL1
            if (core_reg.is_read) begin
              core_next.state = i2cra_pkg::I2CRA_TX;
              core_next.shift = {i_rdata[6:0], 1'b0};
              // Bit 7 goes out at this fall so it settles before the rise
              core_next.pin = '{sda_o: 1'b0, sda_oe: ~i_rdata[7]};
              core_next.req.rd_stb = 1'b1;
              core_next.req.addr = core_reg.reg_addr;
              core_next.reg_addr = next_addr(core_reg.reg_addr, i_trap); // RL6
              core_next.bitcnt = 4'h1;
            end else begin
              core_next.state = i2cra_pkg::I2CRA_RX;
            end
          end
        end
        i2cra_pkg::I2CRA_TX: begin
          if (scl_fall) begin
            if (core_reg.bitcnt == i2cra_pkg::BIT_ACK) begin
              core_next.pin = '0;
              core_next.state = i2cra_pkg::I2CRA_MACK;
            end else begin
              core_next.pin = '{sda_o: 1'b0, sda_oe: ~core_reg.shift[7]};
              core_next.shift = {core_reg.shift[6:0], 1'b0};
              core_next.bitcnt = core_reg.bitcnt + 4'h1;
            end
          end
        end
        i2cra_pkg::I2CRA_MACK: begin
          if (scl_rise) begin
            if (sda) begin
              // No-acknowledge leaves line released for the stop
              core_next.state = i2cra_pkg::I2CRA_IDLE; // RL5
            end else begin
              // Present next register early so read data settles before the fall
              core_next.state = i2cra_pkg::I2CRA_ACK; // RL5
              core_next.req.addr = core_reg.reg_addr; // RL6
            end
          end
        end
        default: begin
          core_next.state = i2cra_pkg::I2CRA_IDLE;
          core_next.pin = '0;
        end
      endcase
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      core_reg <= '0;
      core_reg.state <= i2cra_pkg::I2CRA_IDLE;
      core_reg.reg_addr <= i2cra_pkg::REG_ADDR_RESET; // RL8
      core_reg.start_addr <= i2cra_pkg::REG_ADDR_RESET; // RL8
    end else begin
      core_reg <= core_next;
    end
  end

  assign o_sda = core_reg.pin;
  assign o_req = core_reg.req;
  assign o_hang_reset = core_reg.hang;
endmodule // i2cra_target

// ===== i2cra_target_asserts.sv
// Purpose: Port checks for the two-wire target
// Assumes: Hang period parameter matches the instance
// Notes: Bound to every target instance
`timescale 1ns/10ps
module i2cra_target_chk #(parameter int HANG_SHORT = 50) (
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  input wire logic i_bus_hang_timer_on,
  input i2cra_pkg::i2cra_pin_t o_sda,
  input i2cra_pkg::i2cra_regreq_t o_req,
  input wire logic o_hang_reset
);
  int run_reg;
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_nrst);
  // Length of the current low-hold by the target
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) run_reg <= 0;
    else run_reg <= o_sda.sda_oe ? run_reg + 1 : 0;
  end
  property p_od; o_sda.sda_o == 1'b0; endproperty
  a_od: assert property (p_od) else $error("data driven high");
  property p_wr_ack; o_req.wr_stb |-> ##[0:1] o_sda.sda_oe; endproperty
  a_wr_ack: assert property (p_wr_ack) else $error("write without ack");
  property p_wr_one; o_req.wr_stb |=> !o_req.wr_stb; endproperty
  a_wr_one: assert property (p_wr_one) else $error("write strobe long");
  property p_rd_one; o_req.rd_stb |=> !o_req.rd_stb; endproperty
  a_rd_one: assert property (p_rd_one) else $error("read strobe long");
  property p_excl; !(o_req.wr_stb && o_req.rd_stb); endproperty
  a_excl: assert property (p_excl) else $error("both strobes");
  property p_off; !i_bus_hang_timer_on && !$past(i_bus_hang_timer_on) |-> !o_hang_reset; endproperty
  a_off: assert property (p_off) else $error("hang fired while off");
  property p_rel; o_hang_reset |-> ##[0:2] !o_sda.sda_oe; endproperty
  a_rel: assert property (p_rel) else $error("hang kept line low");
  property p_cause; o_hang_reset |-> run_reg >= HANG_SHORT - 2; endproperty
  a_cause: assert property (p_cause) else $error("hang fired early");
endmodule // i2cra_target_chk
bind i2cra_target i2cra_target_chk #(.HANG_SHORT(HANG_SHORT)) i2cra_target_chk_i (.i_ref_clk(i_ref_clk),
  .i_nrst(i_nrst), .i_bus_hang_timer_on(i_bus_hang_timer_on), .o_sda(o_sda), .o_req(o_req),
  .o_hang_reset(o_hang_reset));

// ===== tb_top.sv
// Purpose: Scenario bench for the two-wire target
// Assumes: Pull-up on data, hang periods shortened
// Notes: Register space returns address xor 5a
`timescale 1ns/10ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin fail_count++; $display("Error %0t: %h vs %h", $time, a, b); end end
module tb_top;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic asel = 1'b0;
  logic hang_on = 1'b0;
  logic hang_sel = 1'b0;
  logic trap = 1'b0;
  logic scl, ctl_low, sda, hang;
  logic [7:0] wa, wd;
  int fail_count = 0;
  int total_checks = 0;
  int rd_cnt = 0;
  i2cra_pkg::i2cra_pin_t pin;
  i2cra_pkg::i2cra_regreq_t req;
  always #50 clk = ~clk;
  assign sda = !(ctl_low || pin.sda_oe);
  i2cra_ctl i2cra_ctl_i (.i_clk(clk), .i_sda(sda), .o_scl(scl), .o_sda_low(ctl_low));
  i2cra_target #(.HANG_SHORT(50), .HANG_LONG(100)) i2cra_target_i (.i_ref_clk(clk), .i_nrst(nrst),
    .i_scl(scl), .i_sda(sda), .i_address_select_pin(asel), .i_bus_hang_timer_on(hang_on),
    .i_bus_hang_period_select(hang_sel), .i_trap(trap), .i_rdata(req.addr ^ 8'h5a), .o_sda(pin),
    .o_req(req), .o_hang_reset(hang));
  always @(posedge clk) begin
    if (req.wr_stb) {wa, wd} <= {req.addr, req.wdata};
    if (req.rd_stb) rd_cnt <= rd_cnt + 1;
  end
  task automatic xw(input logic [7:0] d, input logic e);
    logic a;
    i2cra_ctl_i.wr(d, a);
    `CHK(a, e)
  endtask
  task automatic xr(input logic n, input logic [7:0] e);
    logic [7:0] d;
    i2cra_ctl_i.rd(n, d);
    `CHK(d, e)
  endtask
  task automatic t_read_reset;
    i2cra_ctl_i.start;
    xw(8'hd1, 1'b0);
    xr(1'b0, 8'h5a);
    xr(1'b1, 8'h5b);
    `CHK(rd_cnt, 2)
    `CHK(pin.sda_oe, 1'b0)
    i2cra_ctl_i.stop;
  endtask
  task automatic t_write;
    i2cra_ctl_i.start;
    xw(8'hd0, 1'b0);
    xw(8'h41, 1'b0);
    xw(8'h01, 1'b0);
    `CHK({wa, wd}, 16'h4101)
    xw(8'h02, 1'b0);
    `CHK({wa, wd}, 16'h4202)
    i2cra_ctl_i.stop;
    trap = 1'b1;
    i2cra_ctl_i.start;
    xw(8'hd0, 1'b0);
    xw(8'h10, 1'b0);
    xw(8'h33, 1'b0);
    xw(8'h34, 1'b0);
    `CHK({wa, wd}, 16'h1034)
    i2cra_ctl_i.stop;
    i2cra_ctl_i.idle_suspend;
    trap = 1'b0;
  endtask
  // Stop with no clock toggle, then a start inside a byte
  task automatic t_glitch;
    logic r;
    i2cra_ctl_i.st(1'b1, 1'b1);
    i2cra_ctl_i.st(1'b1, 1'b0);
    i2cra_ctl_i.st(1'b0, 1'b0);
    xw(8'hd0, 1'b0);
    for (int k = 0; k < 4; k++) begin
      i2cra_ctl_i.bit_io(1'b0, r);
    end
    i2cra_ctl_i.start;
    xw(8'hd1, 1'b0);
    xr(1'b1, 8'h7a);
    i2cra_ctl_i.stop;
  endtask
  task automatic t_read_rep;
    i2cra_ctl_i.start;
    xw(8'hd0, 1'b0);
    xw(8'h20, 1'b0);
    i2cra_ctl_i.start;
    xw(8'hd1, 1'b0);
    xr(1'b0, 8'h7a);
    xr(1'b1, 8'h7b);
    i2cra_ctl_i.stop;
    i2cra_ctl_i.start;
    xw(8'hd1, 1'b0);
    xr(1'b1, 8'h7a);
    i2cra_ctl_i.stop;
  endtask
  task automatic t_addr;
    i2cra_ctl_i.start;
    xw(8'hd2, 1'b1);
    i2cra_ctl_i.stop;
    i2cra_ctl_i.start;
    xw(8'hf0, 1'b1);
    i2cra_ctl_i.stop;
    asel = 1'b1;
    i2cra_ctl_i.start;
    xw(8'hd2, 1'b0);
    i2cra_ctl_i.stop;
    asel = 1'b0;
  endtask
  // Stall the clock low while the target acknowledges
  task automatic t_hang(input logic on, input logic sel, input int lim);
    int n;
    logic r;
    logic [7:0] d;
    d = 8'hd0;
    n = 0;
    hang_on = on;
    hang_sel = sel;
    i2cra_ctl_i.start;
    for (int k = 7; k >= 0; k--) begin
      i2cra_ctl_i.bit_io(d[k], r);
    end
    while (hang !== 1'b1 && n < 300) begin
      @(negedge clk);
      n++;
    end
    if (on) begin
      `CHK(n inside {[lim - 12:lim + 4]}, 1'b1)
    end else begin
      `CHK(n, 300)
    end
    hang_on = 1'b1;
    repeat (200) @(negedge clk);
    `CHK(pin.sda_oe, 1'b0)
    i2cra_ctl_i.stop;
  endtask
  task automatic report_and_stop;
    $display("checks %0d errors %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    repeat (4) @(negedge clk);
    nrst = 1'b1;
    repeat (6) @(negedge clk);
    t_read_reset;
    t_write;
    t_read_rep;
    t_addr;
    t_glitch;
    t_hang(1'b0, 1'b0, 50);
    t_hang(1'b1, 1'b0, 50);
    t_hang(1'b1, 1'b1, 100);
    report_and_stop;
  end
  initial begin
    repeat (80000) @(posedge clk);
    fail_count++;
    report_and_stop;
  end
endmodule // tb_top
